// [dmca_pkg.sv]
package dmca_pkg;

   // ------------------------------------------------------------
   // Sizes and map
   // ------------------------------------------------------------
   localparam int          NUM_CH       = 4;
   localparam int          CH_W         = 2;
   localparam int          ADDR_W       = 12;
   localparam int          CRC_CH       = 0;
   localparam int          FILL_CH      = 1;
   localparam logic [5:0]  MAIN_CTRL    = 6'h00;
   localparam logic [5:0]  STAGED_WORD  = 6'h04;
   localparam logic [5:0]  CH_ENABLE    = 6'h00;
   localparam logic [5:0]  MEM_BEGIN    = 6'h04;
   localparam logic [5:0]  MEM_LIMIT    = 6'h08;
   localparam logic [5:0]  PEER_PTR     = 6'h0c;
   localparam logic [5:0]  CH_CTRL      = 6'h10;
   localparam logic [5:0]  INT_STATUS   = 6'h14;
   localparam logic [5:0]  INT_ENABLE   = 6'h18;
   localparam logic [5:0]  OPT_ENABLE   = 6'h20;
   localparam logic [5:0]  OPT_DATA     = 6'h24;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int          ACT_BIT      = 0;
   localparam int          SRST_BIT     = 1;
   localparam int          ABORT_BIT    = 25;
   localparam int          GO_BIT       = 24;
   localparam int          SIZE_LSB     = 20;
   localparam int          DIS_HW_BIT   = 19;
   localparam int          INC_DEV_BIT  = 17;
   localparam int          INC_MEM_BIT  = 16;
   localparam logic [31:0] CTRL_MASK    = 32'h037f_0000;
   localparam int          ST_DONE      = 0;
   localparam int          ST_ABORT     = 1;
   localparam int          ST_TERM      = 2;
   localparam int          ST_W         = 3;
   localparam logic [31:0] WORD_RST     = 32'h0000_0000;

   typedef struct packed {
      logic            en;
      logic [5:0]      off;
      logic [31:0]     data;
   } dmca_wr_type;

   typedef struct packed {
      logic            valid;
      logic            term;
      logic [CH_W-1:0] chan;
      logic [31:0]     data;
   } dmca_pkt_type;

   typedef struct packed {
      logic            valid;
      logic [CH_W-1:0] chan;
      logic [31:0]     mem_addr;
      logic [31:0]     peer_addr;
      logic [31:0]     data;
   } dmca_xfer_type;

endpackage

// [dmca_chan.sv]
`timescale 1ns/1ps

module dmca_chan #(
   parameter int CH_IDX = 0
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 soft_rst,
   input  wire logic                 main_act,
   input  wire dmca_pkg::dmca_wr_type wr,
   input  wire logic [5:0]           rd_off,
   output logic [31:0]               rd_data,
   input  wire logic                 step,
   input  wire logic                 term,
   output logic                      can_hw,
   output logic                      want_fw,
   output logic [31:0]               mem_ptr,
   output logic [31:0]               peer_ptr,
   output logic                      irq
);

   localparam bit HAS_OPT = (CH_IDX == dmca_pkg::CRC_CH) || (CH_IDX == dmca_pkg::FILL_CH);

   logic                       act;
   logic [31:0]                limit;
   logic [31:0]                ctrl;
   logic [31:0]                opt_data;
   logic                       opt_en;
   logic [dmca_pkg::ST_W-1:0]  ist;
   logic [dmca_pkg::ST_W-1:0]  ien;
   logic [31:0]                sz;
   logic [31:0]                next_mem;
   logic                       run;
   logic                       hit_done;

   function automatic logic hit(input logic [5:0] o);
      return wr.en && (wr.off == o);
   endfunction

   assign sz       = {29'h0, ctrl[dmca_pkg::SIZE_LSB +: 3]};
   assign next_mem = mem_ptr + sz;
   // Any set status bit parks the channel until firmware clears it
   assign run      = act & main_act & ~|ist;
   assign can_hw   = run & ~ctrl[dmca_pkg::DIS_HW_BIT];
   assign want_fw  = run & ctrl[dmca_pkg::DIS_HW_BIT] & ctrl[dmca_pkg::GO_BIT];
   assign hit_done = step & ctrl[dmca_pkg::INC_MEM_BIT] & (next_mem == limit);
   assign irq      = |(ist & ien);

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act <= 1'b0;
      end else if (soft_rst) begin
         act <= 1'b0;
      end else if (hit(dmca_pkg::CH_ENABLE)) begin
         act <= wr.data[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ptr <= dmca_pkg::WORD_RST;
      end else if (soft_rst) begin
         mem_ptr <= dmca_pkg::WORD_RST;
      end else if (hit(dmca_pkg::MEM_BEGIN)) begin
         mem_ptr <= wr.data;
      end else if (step && ctrl[dmca_pkg::INC_MEM_BIT]) begin
         mem_ptr <= next_mem;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peer_ptr <= dmca_pkg::WORD_RST;
      end else if (soft_rst) begin
         peer_ptr <= dmca_pkg::WORD_RST;
      end else if (hit(dmca_pkg::PEER_PTR)) begin
         peer_ptr <= wr.data;
      end else if (step && ctrl[dmca_pkg::INC_DEV_BIT]) begin
         peer_ptr <= peer_ptr + sz;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit <= dmca_pkg::WORD_RST;
      end else if (soft_rst) begin
         limit <= dmca_pkg::WORD_RST;
      end else if (hit(dmca_pkg::MEM_LIMIT)) begin
         limit <= wr.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= dmca_pkg::WORD_RST;
      end else if (soft_rst) begin
         ctrl <= dmca_pkg::WORD_RST;
      end else if (hit(dmca_pkg::CH_CTRL)) begin
         ctrl <= wr.data & dmca_pkg::CTRL_MASK;
      end else if (hit_done || term || ctrl[dmca_pkg::ABORT_BIT]) begin
         ctrl[dmca_pkg::GO_BIT] <= 1'b0;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist <= '0;
      end else if (soft_rst) begin
         ist <= '0;
      end else begin
         ist <= (ist & ~(hit(dmca_pkg::INT_STATUS) ? wr.data[dmca_pkg::ST_W-1:0] : '0))
                | {term & can_hw, ctrl[dmca_pkg::ABORT_BIT] & act, hit_done};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien <= '0;
      end else if (soft_rst) begin
         ien <= '0;
      end else if (hit(dmca_pkg::INT_ENABLE)) begin
         ien <= wr.data[dmca_pkg::ST_W-1:0];
      end
   end

   // Option group exists only on the checksum and fill channels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_en   <= 1'b0;
         opt_data <= dmca_pkg::WORD_RST;
      end else if (soft_rst || !HAS_OPT) begin
         opt_en   <= 1'b0;
         opt_data <= dmca_pkg::WORD_RST;
      end else begin
         if (hit(dmca_pkg::OPT_ENABLE)) begin
            opt_en <= wr.data[0];
         end
         if (hit(dmca_pkg::OPT_DATA)) begin
            opt_data <= wr.data;
         end
      end
   end

   always_comb begin
      case (rd_off)
         dmca_pkg::CH_ENABLE:  rd_data = {31'h0, act};
         dmca_pkg::MEM_BEGIN:  rd_data = mem_ptr;
         dmca_pkg::MEM_LIMIT:  rd_data = limit;
         dmca_pkg::PEER_PTR:   rd_data = peer_ptr;
         dmca_pkg::CH_CTRL:    rd_data = ctrl;
         dmca_pkg::INT_STATUS: rd_data = {29'h0, ist};
         dmca_pkg::INT_ENABLE: rd_data = {29'h0, ien};
         dmca_pkg::OPT_ENABLE: rd_data = {31'h0, opt_en};
         dmca_pkg::OPT_DATA:   rd_data = opt_data;
         default:              rd_data = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_mem_step: assert property (@(posedge pclk) disable iff (!presetn)
      step && ctrl[dmca_pkg::INC_MEM_BIT] && !soft_rst && !hit(dmca_pkg::MEM_BEGIN)
      |=> mem_ptr == $past(mem_ptr) + $past(sz))
      else $error("memory pointer did not advance by packet size");

   a_peer_step: assert property (@(posedge pclk) disable iff (!presetn)
      step && ctrl[dmca_pkg::INC_DEV_BIT] && !soft_rst && !hit(dmca_pkg::PEER_PTR)
      |=> peer_ptr == $past(peer_ptr) + $past(sz))
      else $error("peer pointer did not advance by packet size");

   a_limit_done: assert property (@(posedge pclk) disable iff (!presetn)
      hit_done && !soft_rst |=> ist[dmca_pkg::ST_DONE] && !ctrl[dmca_pkg::GO_BIT] ##1 !run)
      else $error("reaching the limit did not end the transfer");

   a_no_limit_stop: assert property (@(posedge pclk) disable iff (!presetn)
      step && !ctrl[dmca_pkg::INC_MEM_BIT] && !hit(dmca_pkg::INT_STATUS)
      |=> $stable(ist[dmca_pkg::ST_DONE]))
      else $error("done raised without memory increment");

   a_chan_gate: assert property (@(posedge pclk) disable iff (!presetn)
      step |-> act && main_act)
      else $error("packet moved on an inactive channel");

endmodule

// [dmca_top.sv]
`timescale 1ns/1ps

// How it works
// - Main block word 04h shows, read-only, the last staged packet word; reset zero.
// - Every channel carries the same register group controlling only itself.
// - Channel control at 10h, status 14h, enable 18h.
// - Checksum enable and data at 20h-24h exist on channel 0 only.
// - Fill enable and value at 20h-24h exist on channel 1 only.
// - Channel enable bit 0 is read-write, reset zero; bits 7:1 reserved.
// - A channel runs only with its own and the block-wide enable set.
// - Memory begin pointer at 04h is read-write and resets to zero.
// - With memory increment on, reaching the limit ends transfer and sets done.
// - Peer pointer at 0Ch is read-write, reset zero, addresses the peer.
// - The peer is the master driving the hardware flow handshake.
// - With peer increment on, the peer pointer grows by packet size per packet.
// - With memory increment on, the memory pointer grows by packet size per packet.
// - Clearing the block-wide enable stops every channel.
module dmca_top (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [dmca_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic [31:0]                       prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire dmca_pkg::dmca_pkt_type       pkt,
   output dmca_pkg::dmca_xfer_type           xfer,
   output logic                              irq
);

   logic                        main_act;
   logic                        soft_rst;
   logic [31:0]                 staged_word;
   logic                        access;
   logic                        wr_fire;
   logic [5:0]                  blk;
   logic [31:0]                 rd_mux;
   logic [dmca_pkg::NUM_CH-1:0] step;
   logic [dmca_pkg::NUM_CH-1:0] can_hw;
   logic [dmca_pkg::NUM_CH-1:0] want_fw;
   logic [dmca_pkg::NUM_CH-1:0] ch_irq;
   logic [dmca_pkg::CH_W-1:0]   step_idx;
   logic                        hw_step;
   logic [31:0]                 ch_rd   [dmca_pkg::NUM_CH];
   logic [31:0]                 ch_mem  [dmca_pkg::NUM_CH];
   logic [31:0]                 ch_peer [dmca_pkg::NUM_CH];

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Whole channel windows answer at word-aligned addresses; holes inside them read as zero
   function automatic logic addr_ok(input logic [dmca_pkg::ADDR_W-1:0] a);
      if (a[11:6] == 6'h00) begin
         return (a[5:0] == dmca_pkg::MAIN_CTRL) || (a[5:0] == dmca_pkg::STAGED_WORD);
      end
      return (a[11:6] <= 6'(dmca_pkg::NUM_CH)) && (a[1:0] == 2'h0);
   endfunction

   assign blk     = paddr[11:6];
   assign access  = psel & penable;
   assign wr_fire = access & pready & pwrite & addr_ok(paddr);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (blk == 6'h00) begin
         if (paddr[5:0] == dmca_pkg::MAIN_CTRL) begin
            rd_mux = {31'h0, main_act};
         end else begin
            rd_mux = staged_word;
         end
      end else if (blk <= 6'(dmca_pkg::NUM_CH)) begin
         rd_mux = ch_rd[dmca_pkg::CH_W'(blk - 6'h01)];
      end
   end

   // One wait state: data are latched in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access & ~pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         prdata  <= (pwrite || !addr_ok(paddr)) ? 32'h0000_0000 : rd_mux;
         pslverr <= ~addr_ok(paddr);
      end
   end

   // ------------------------------------------------------------
   // Main block
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_fire && (paddr[11:0] == 12'(dmca_pkg::MAIN_CTRL))
                     && pwdata[dmca_pkg::SRST_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_act <= 1'b0;
      end else if (soft_rst) begin
         main_act <= 1'b0;
      end else if (wr_fire && (paddr[11:0] == 12'(dmca_pkg::MAIN_CTRL))) begin
         main_act <= pwdata[dmca_pkg::ACT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         staged_word <= dmca_pkg::WORD_RST;
      end else if (soft_rst) begin
         staged_word <= dmca_pkg::WORD_RST;
      end else if (hw_step) begin
         staged_word <= pkt.data;
      end
   end

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < dmca_pkg::NUM_CH; i++) begin : g_ch
      dmca_pkg::dmca_wr_type ch_wr;

      assign ch_wr = {wr_fire && (blk == 6'(i + 1)), paddr[5:0], pwdata};

      dmca_chan #(
         .CH_IDX (i)
      ) u_chan (
         .pclk     (pclk),
         .presetn  (presetn),
         .soft_rst (soft_rst),
         .main_act (main_act),
         .wr       (ch_wr),
         .rd_off   (paddr[5:0]),
         .rd_data  (ch_rd[i]),
         .step     (step[i]),
         .term     (pkt.valid && pkt.term && (pkt.chan == dmca_pkg::CH_W'(i))),
         .can_hw   (can_hw[i]),
         .want_fw  (want_fw[i]),
         .mem_ptr  (ch_mem[i]),
         .peer_ptr (ch_peer[i]),
         .irq      (ch_irq[i])
      );
   end

   // A peer packet has priority; firmware-paced channels share the
   // remaining cycles, lowest number first, one packet per cycle
   always_comb begin
      logic found;
      found    = 1'b0;
      step     = '0;
      step_idx = '0;
      hw_step  = pkt.valid && !pkt.term && can_hw[pkt.chan];
      if (hw_step) begin
         step[pkt.chan] = 1'b1;
         step_idx       = pkt.chan;
      end else begin
         for (int i = 0; i < dmca_pkg::NUM_CH; i++) begin
            if (want_fw[i] && !found) begin
               step[i]  = 1'b1;
               step_idx = dmca_pkg::CH_W'(i);
               found    = 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer <= '0;
      end else begin
         xfer.valid     <= |step;
         xfer.chan      <= step_idx;
         xfer.mem_addr  <= ch_mem[step_idx];
         xfer.peer_addr <= ch_peer[step_idx];
         xfer.data      <= hw_step ? pkt.data : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |ch_irq;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_staged_word: assert property (@(posedge pclk) disable iff (!presetn)
      hw_step && !soft_rst |=> staged_word == $past(pkt.data))
      else $error("staged word not taken from the packet");

   a_gate_activate: assert property (@(posedge pclk) disable iff (!presetn)
      !main_act |=> !xfer.valid)
      else $error("transfer issued with the block disabled");

   a_soft_clear: assert property (@(posedge pclk) disable iff (!presetn)
      soft_rst |=> !main_act && staged_word == 32'h0000_0000)
      else $error("soft reset left state behind");

   a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
      access && !pready && !pwrite && blk > 6'h02 && blk <= 6'(dmca_pkg::NUM_CH)
      && paddr[5:0] >= dmca_pkg::OPT_ENABLE |=> pready && prdata == 32'h0000_0000)
      else $error("option word read nonzero on a plain channel");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable ##1 access |-> !pready ##1 pready ##1 !pready)
      else $error("bus answer not one wait state");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq == $past(|ch_irq))
      else $error("interrupt does not follow channel status");

   c_hw_packet: cover property (@(posedge pclk) disable iff (!presetn) hw_step);
   c_fw_packet: cover property (@(posedge pclk) disable iff (!presetn) |step && !hw_step);
   c_done_irq:  cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_bus_error: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

// [dmca_peer.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Peripheral master on the hardware flow handshake
// ------------------------------------------------------------
module dmca_peer (
   input  wire logic              pclk,
   output dmca_pkg::dmca_pkt_type pkt
);
   initial pkt = '0;

   // Gap zero gives back-to-back packets, larger gaps a slow peer.
   // Idle cycles carry changing junk, so a design that ignores valid is caught.
   task automatic send(input logic [1:0] ch, input int n, input logic term, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         pkt <= {1'b1, term && (i == n - 1), ch, $urandom()};
         if (gap > 0) begin
            @(posedge pclk);
            pkt <= {2'b00, ch, ~pkt.data};
            repeat (gap - 1) @(posedge pclk);
         end
      end
      @(posedge pclk);
      pkt <= {4'h0, $urandom()};
   endtask
endmodule

// [dmca_top_test.sv]
`timescale 1ns/1ps

module dmca_top_test;
   logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [dmca_pkg::ADDR_W-1:0] paddr;
   logic [31:0]                 pwdata, prdata, rv, stg;
   dmca_pkg::dmca_pkt_type      pkt;
   dmca_pkg::dmca_xfer_type     xfer, ex;
   int                          mismatches, check_count, b;
   logic                        act;
   logic                        en[4]    = '{default: 0};
   logic [31:0]                 mp[4]    = '{default: 0};
   logic [31:0]                 pp[4]    = '{default: 0};
   logic [31:0]                 lim[4]   = '{default: 0};
   logic [31:0]                 ctl[4]   = '{default: 0};
   logic [2:0]                  st[4]    = '{default: 0};
   logic [2:0]                  ie[4]    = '{default: 0};

   dmca_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pkt(pkt), .xfer(xfer), .irq(irq));
   dmca_peer u_peer (.pclk(pclk), .pkt(pkt));

   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end

   task automatic check(input string nm, input logic [98:0] seen, input logic [98:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Reference model: register writes and accepted packets
   // ------------------------------------------------------------
   task automatic mwrite(input int a, input logic [31:0] d);
      int c;
      int o;
      c = a / 64 - 1;
      o = a % 64;
      if (a == 0) begin
         act = d[0] && !d[1];
         // Soft reset clears every register of the block
         if (d[1]) begin
            stg = '0;
            for (int k = 0; k < 4; k++) begin
               {en[k], mp[k], pp[k], lim[k], ctl[k], st[k], ie[k]} = '0;
            end
         end
      end else if (c >= 0 && c < 4) begin
         case (o)
            0: en[c] = d[0];
            4: mp[c] = d;
            8: lim[c] = d;
            12: pp[c] = d;
            16: begin
               ctl[c] = d & dmca_pkg::CTRL_MASK;
               if (d[25] && en[c]) st[c] |= 3'b010;
            end
            20: st[c] &= ~d[2:0];
            24: ie[c] = d[2:0];
         endcase
      end
   endtask

   function automatic logic [31:0] mreg(int c, int o);
      case (o)
         0: return {31'h0, en[c]};
         4: return mp[c];
         8: return lim[c];
         default: return pp[c];
      endcase
   endfunction

   task automatic mstep(input int c, input logic [31:0] d);
      ex = {1'b1, 2'(c), mp[c], pp[c], d};
      if (ctl[c][16]) mp[c] += ctl[c][22:20];
      if (ctl[c][17]) pp[c] += ctl[c][22:20];
      if (ctl[c][16] && mp[c] == lim[c]) begin
         st[c] |= 3'b001;
         ctl[c][24] = 1'b0;
      end
   endtask

   always @(posedge pclk) begin
      int c;
      if (presetn && (ex.valid || xfer.valid)) check("xfer", xfer, ex);
      ex = '0;
      c = pkt.chan;
      if (presetn && pkt.valid && act && en[c] && !ctl[c][19] && st[c] == 0) begin
         if (pkt.term) st[c] |= 3'b100;
         else begin
            stg = pkt.data;
            mstep(c, pkt.data);
         end
      end
      // Firmware-paced channels take the cycles that no peer packet uses
      for (int k = 0; k < 4; k++) begin
         if (presetn && !ex.valid && act && en[k] && ctl[k][19] && ctl[k][24] && st[k] == 0) begin
            mstep(k, '0);
         end
      end
   end

   // ------------------------------------------------------------
   // APB master
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input int a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, 12'(a), d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) mismatches++;
      rv = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      // The model moves off the edge so packet prediction never races a write
      @(negedge pclk);
      if (wr && !err) mwrite(a, d);
   endtask

   task automatic rdchk(input string nm, input int a, input logic [31:0] e);
      apb(0, a, 0);
      check(nm, rv, e);
   endtask

   task automatic settle;
      logic e;
      repeat (3) @(posedge pclk);
      e = 0;
      for (int c = 0; c < 4; c++) e |= |(st[c] & ie[c]);
      check("irq", irq, e);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, act, stg} = '0;
      {mismatches, check_count} = '0;
      ex = '0;
      void'($urandom(28070));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("staged", 4, 0);
      for (int c = 0; c < 4; c++) for (int o = 0; o < 16; o += 4) rdchk("rst", (c + 1) * 64 + o, 0);
      $display("test reset done");
      for (int c = 0; c < 4; c++) for (int o = 0; o < 16; o += 4) apb(1, (c + 1) * 64 + o, o == 0 ? 32'hff : $urandom());
      for (int c = 0; c < 4; c++) begin
         b = (c + 1) * 64;
         for (int o = 0; o < 16; o += 4) rdchk("reg", b + o, mreg(c, o));
         apb(1, b + 32, 1);
         rdchk("opt", b + 32, c < 2);
         rdchk("opt28", b + 40, 0);
      end
      apb(0, 8, 0);
      check("slverr", err, 1);
      apb(1, 4, 32'hffff);
      rdchk("staged_ro", 4, 0);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         b = (i + 1) * 64;
         apb(1, b + 4, 32'h100);
         apb(1, b + 8, 32'h100 + 3 * (1 << i));
         apb(1, b + 24, 3'h7);
         apb(1, b + 16, 32'h3 << 16 | (1 << i) << 20);
         apb(1, 0, 1);
         u_peer.send(i, 4, 0, i);
         settle;
         for (int o = 4; o < 16; o += 4) rdchk("ptr", b + o, mreg(i, o));
         rdchk("status", b + 20, st[i]);
         apb(1, b + 20, 3'h7);
         settle;
      end
      $display("test stepping done");
      apb(1, 256 + 4, 32'h40);
      apb(1, 256 + 8, 32'h44);
      apb(1, 256 + 24, 0);
      apb(1, 256 + 16, 32'h2 << 16 | 4 << 20);
      u_peer.send(3, 3, 0, 0);
      rdchk("no_limit", 256 + 20, 0);
      rdchk("staged", 4, stg);
      apb(1, 0, 0);
      u_peer.send(3, 2, 0, 1);
      apb(1, 0, 1);
      apb(1, 256, 0);
      u_peer.send(3, 2, 0, 0);
      apb(1, 256, 1);
      u_peer.send(3, 2, 1, 0);
      settle;
      apb(1, 256 + 24, 3'h4);
      settle;
      rdchk("term", 256 + 20, 3'h4);
      apb(1, 256 + 20, 3'h4);
      settle;
      $display("test gating done");
      b = 64;
      apb(1, b + 4, 32'h200);
      apb(1, b + 8, 32'h208);
      apb(1, b + 16, 32'h0149_0000);
      repeat (3) @(posedge pclk);
      rdchk("fw_ptr", b + 4, mp[0]);
      rdchk("go", b + 16, ctl[0]);
      settle;
      apb(1, b + 20, 3'h7);
      apb(1, b + 16, 32'h0200_0000);
      rdchk("abort", b + 20, st[0]);
      apb(1, b + 16, 0);
      apb(1, b + 20, 3'h7);
      settle;
      $display("test firmware done");
      apb(1, 0, 3);
      for (int c = 0; c < 4; c++) begin
         for (int o = 0; o < 28; o += 4) rdchk("soft", (c + 1) * 64 + o, 0);
      end
      rdchk("soft_staged", 4, 0);
      settle;
      $display("test soft reset done");
      give_verdict;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      give_verdict;
   end
endmodule
